// ### hw/ivs_syn_upd.sv
// Syndrome next-value logic of the interrupt vector and syndrome block.
// Assumes one interrupt is offered per cycle by the sequencer.
`timescale 1ns/10ps
`include "ivs_defs.svh"

module ivs_syn_upd
(
	input wire ivs_pkg::ivs_take_t take,
	input wire logic [15:0] syn_types,
	input wire ivs_pkg::ivs_cause_t current,
	output ivs_pkg::ivs_cause_t next,
	output logic hit
);

	// A recording type replaces the whole syndrome; the others leave it.
	assign hit = take.valid & syn_types[take.int_type];
	assign next = hit ? take.cause : current;

endmodule // ivs_syn_upd

// ### hw/ivs_top.sv
// Interrupt vector offsets, vector prefix and exception syndrome.
// Assumes the core sequencer and the special-register path share clk.
`timescale 1ns/10ps
`include "ivs_defs.svh"

module ivs_top
#(
	parameter int NUM_TYPES = 16,
	parameter logic [15:0] SYN_TYPES = `IVS_SYN_TYPES
)
(
	input wire logic clk,
	input wire logic rstn,
	input wire ivs_pkg::ivs_take_t take,
	input wire ivs_pkg::ivs_spr_req_t spr_req,
	output logic [31:0] spr_rdata,
	output logic spr_rvalid,
	output logic spr_miss,
	output logic [31:0] vector_addr,
	output logic vector_valid,
	output ivs_pkg::ivs_int_type_t vector_type,
	output logic syndrome_updated
);

////////////////////////////////////////////////////////////////////////////////

	// The type field is four bits wide, so the table cannot grow or shrink.
	if (NUM_TYPES != 16)
	begin : g_bad_types
		$error("ivs_top serves exactly sixteen interrupt types");
	end

	function automatic logic [31:0] place_offset(input logic [`IVS_OFF_W-1:0] off);
		place_offset = `IVS_WORD_ZERO;
		place_offset[`IVS_OFF_MSB:`IVS_OFF_LSB] = off;
	endfunction

	function automatic logic [31:0] place_syndrome(input ivs_pkg::ivs_cause_t c);
		place_syndrome = `IVS_WORD_ZERO;
		place_syndrome[`IVS_SYN_FETCH_MC] = c.fetch_machine_check_flag;
		place_syndrome[`IVS_SYN_ILLEGAL] = c.illegal_instr_flag;
		place_syndrome[`IVS_SYN_PRIV] = c.privileged_instr_flag;
		place_syndrome[`IVS_SYN_TRAP] = c.trap_flag;
		place_syndrome[`IVS_SYN_FLOAT] = c.float_op_flag;
	endfunction

	function automatic ivs_pkg::ivs_cause_t pick_syndrome(input logic [31:0] w);
		pick_syndrome.fetch_machine_check_flag = w[`IVS_SYN_FETCH_MC];
		pick_syndrome.illegal_instr_flag = w[`IVS_SYN_ILLEGAL];
		pick_syndrome.privileged_instr_flag = w[`IVS_SYN_PRIV];
		pick_syndrome.trap_flag = w[`IVS_SYN_TRAP];
		pick_syndrome.float_op_flag = w[`IVS_SYN_FLOAT];
	endfunction

////////////////////////////////////////////////////////////////////////////////

	// Only the defined fields are stored; reserved bits have no flops.
	logic [`IVS_OFF_W-1:0] vector_offset_reg [NUM_TYPES];
	logic [`IVS_OFF_W-1:0] vector_offset_next [NUM_TYPES];
	logic [`IVS_PFX_W-1:0] vector_prefix_reg;
	logic [`IVS_PFX_W-1:0] vector_prefix_next;
	ivs_pkg::ivs_cause_t exception_syndrome_reg;
	ivs_pkg::ivs_cause_t exception_syndrome_next;
	ivs_pkg::ivs_cause_t syn_from_take;
	logic syn_hit;
	logic [31:0] vec_addr_now;
	logic [31:0] vector_addr_reg;
	logic vector_valid_reg;
	ivs_pkg::ivs_int_type_t vector_type_reg;
	logic syndrome_updated_reg;
	logic [31:0] spr_rdata_reg;
	logic [31:0] spr_rdata_next;
	logic spr_rvalid_reg;
	logic spr_miss_reg;

////////////////////////////////////////////////////////////////////////////////

	// Special-register number decode.
	wire hit_offset = (spr_req.num >= `IVS_SPR_OFF_BASE) && (spr_req.num <= `IVS_SPR_OFF_LAST);
	wire hit_prefix = (spr_req.num == `IVS_SPR_PREFIX);
	wire hit_syndrome = (spr_req.num == `IVS_SPR_SYNDROME);
	wire hit_any = hit_offset | hit_prefix | hit_syndrome;
	wire [3:0] off_index = spr_req.num[3:0];
	wire wr_offset = spr_req.wr & hit_offset;
	wire wr_prefix = spr_req.wr & hit_prefix;
	wire wr_syndrome = spr_req.wr & hit_syndrome;
	wire access = spr_req.wr | spr_req.rd;

	// Reserved bits of the write data are dropped here.
	wire [`IVS_OFF_W-1:0] wr_off_field = spr_req.wdata[`IVS_OFF_MSB:`IVS_OFF_LSB];
	wire [`IVS_PFX_W-1:0] wr_pfx_field = spr_req.wdata[`IVS_PFX_MSB:`IVS_PFX_LSB];
	wire ivs_pkg::ivs_cause_t wr_syn_field = pick_syndrome(spr_req.wdata);

////////////////////////////////////////////////////////////////////////////////

	// Offset table: the interrupt type indexes it directly.
	for (genvar i = 0; i < NUM_TYPES; i++)
	begin : g_offset
		assign vector_offset_next[i] = (wr_offset && (off_index == 4'(i))) ?
			wr_off_field : vector_offset_reg[i];

		always_ff @(posedge clk)
		begin
			if (!rstn)
				vector_offset_reg[i] <= `IVS_RST_OFF;
			else
				vector_offset_reg[i] <= vector_offset_next[i];
		end
	end

	assign vector_prefix_next = wr_prefix ? wr_pfx_field : vector_prefix_reg;

	always_ff @(posedge clk)
	begin
		if (!rstn)
			vector_prefix_reg <= `IVS_RST_PFX;
		else
			vector_prefix_reg <= vector_prefix_next;
	end

////////////////////////////////////////////////////////////////////////////////

	// A write to the offset or prefix in the cycle of an interrupt does not
	// steer that interrupt: it uses the values that stood before the write.
	wire [`IVS_OFF_W-1:0] sel_offset = vector_offset_reg[take.int_type];

	ivs_vec_form u_vec_form
	(
		.prefix(vector_prefix_reg),
		.offset(sel_offset),
		.vector_addr(vec_addr_now)
	);

	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			vector_addr_reg <= `IVS_WORD_ZERO;
			vector_valid_reg <= 1'b0;
			vector_type_reg <= ivs_pkg::IVS_CRITICAL_INPUT;
		end
		else
		begin
			vector_valid_reg <= take.valid;
			if (take.valid)
			begin
				vector_addr_reg <= vec_addr_now;
				vector_type_reg <= take.int_type;
			end
		end
	end

	assign vector_addr = vector_addr_reg;
	assign vector_valid = vector_valid_reg;
	assign vector_type = vector_type_reg;

////////////////////////////////////////////////////////////////////////////////

	// The hardware update of the syndrome wins over a software write in the
	// same cycle, so the cause of the interrupt is never lost.
	ivs_syn_upd u_syn_upd
	(
		.take(take),
		.syn_types(SYN_TYPES),
		.current(exception_syndrome_reg),
		.next(syn_from_take),
		.hit(syn_hit)
	);

	assign exception_syndrome_next = syn_hit ? syn_from_take :
		(wr_syndrome ? wr_syn_field : exception_syndrome_reg);

	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			exception_syndrome_reg <= `IVS_RST_SYN;
			syndrome_updated_reg <= 1'b0;
		end
		else
		begin
			exception_syndrome_reg <= exception_syndrome_next;
			syndrome_updated_reg <= syn_hit;
		end
	end

	assign syndrome_updated = syndrome_updated_reg;

////////////////////////////////////////////////////////////////////////////////

	// Read data is the value before any write of the same cycle.
	wire [31:0] rd_offset_word = place_offset(vector_offset_reg[off_index]);
	wire [31:0] rd_prefix_word = {vector_prefix_reg, 16'h0000};
	wire [31:0] rd_syndrome_word = place_syndrome(exception_syndrome_reg);

	assign spr_rdata_next = !spr_req.rd ? spr_rdata_reg :
		hit_offset ? rd_offset_word :
		hit_prefix ? rd_prefix_word :
		hit_syndrome ? rd_syndrome_word :
		`IVS_WORD_ZERO;

	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			spr_rdata_reg <= `IVS_WORD_ZERO;
			spr_rvalid_reg <= 1'b0;
			spr_miss_reg <= 1'b0;
		end
		else
		begin
			spr_rdata_reg <= spr_rdata_next;
			spr_rvalid_reg <= spr_req.rd;
			spr_miss_reg <= access & ~hit_any;
		end
	end

	assign spr_rdata = spr_rdata_reg;
	assign spr_rvalid = spr_rvalid_reg;
	assign spr_miss = spr_miss_reg;

endmodule // ivs_top

// ### hw/ivs_vec_form.sv
// Vector address former of the interrupt vector and syndrome block.
// Assumes the caller has already selected the offset for the type taken.
`timescale 1ns/10ps
`include "ivs_defs.svh"

module ivs_vec_form
(
	input wire logic [`IVS_PFX_W-1:0] prefix,
	input wire logic [`IVS_OFF_W-1:0] offset,
	output logic [31:0] vector_addr
);

	// Four low zero bits keep every vector on a 16-byte boundary.
	assign vector_addr = {prefix, offset, `IVS_ALIGN_ZERO};

endmodule // ivs_vec_form

// ### shared/ivs_defs.svh
// Constants of the interrupt vector and syndrome block.
// Assumes nothing of its surroundings; include by bare name.
`ifndef IVS_DEFS_SVH
`define IVS_DEFS_SVH

// Special-register numbers decoded by the block.
`define IVS_SPR_NUM_W 10
`define IVS_SPR_OFF_BASE 10'h100
`define IVS_SPR_OFF_LAST 10'h10F
`define IVS_SPR_PREFIX 10'h110
`define IVS_SPR_SYNDROME 10'h111

// Field positions in the 32-bit word, bit 31 being the leftmost bit 0.
`define IVS_OFF_MSB 15
`define IVS_OFF_LSB 4
`define IVS_OFF_W 12
`define IVS_PFX_MSB 31
`define IVS_PFX_LSB 16
`define IVS_PFX_W 16
`define IVS_ALIGN_ZERO 4'h0

// Syndrome bit positions.
`define IVS_SYN_FETCH_MC 31
`define IVS_SYN_ILLEGAL 27
`define IVS_SYN_PRIV 26
`define IVS_SYN_TRAP 25
`define IVS_SYN_FLOAT 24

// Reset values.
`define IVS_RST_OFF 12'h000
`define IVS_RST_PFX 16'h0000
`define IVS_RST_SYN 5'h00
`define IVS_WORD_ZERO 32'h00000000

// Interrupt types that record a syndrome: machine check, data storage,
// instruction storage, alignment, program and data TLB error.
`define IVS_SYN_TYPES 16'h206E

`endif

// ### shared/ivs_pkg.sv
// Types shared by the interrupt vector and syndrome block.
// Assumes ivs_defs.svh is on the include path.
`include "ivs_defs.svh"

package ivs_pkg;

	typedef enum logic [3:0] {
		IVS_CRITICAL_INPUT = 4'h0,
		IVS_MACHINE_CHECK = 4'h1,
		IVS_DATA_STORAGE = 4'h2,
		IVS_INSTR_STORAGE = 4'h3,
		IVS_EXTERNAL_INPUT = 4'h4,
		IVS_ALIGNMENT = 4'h5,
		IVS_PROGRAM = 4'h6,
		IVS_FLOAT_UNAVAIL = 4'h7,
		IVS_SYSTEM_CALL = 4'h8,
		IVS_AUX_UNAVAIL = 4'h9,
		IVS_DECREMENTER = 4'hA,
		IVS_FIXED_INTERVAL = 4'hB,
		IVS_WATCHDOG = 4'hC,
		IVS_DATA_TLB_ERROR = 4'hD,
		IVS_INSTR_TLB_ERROR = 4'hE,
		IVS_DEBUG = 4'hF
	} ivs_int_type_t;

	// Stored syndrome fields, leftmost first.
	typedef struct packed {
		logic fetch_machine_check_flag;
		logic illegal_instr_flag;
		logic privileged_instr_flag;
		logic trap_flag;
		logic float_op_flag;
	} ivs_cause_t;

	// One interrupt being taken by the sequencer.
	typedef struct packed {
		logic valid;
		ivs_int_type_t int_type;
		ivs_cause_t cause;
	} ivs_take_t;

	// One move-to or move-from special register request.
	typedef struct packed {
		logic wr;
		logic rd;
		logic [`IVS_SPR_NUM_W-1:0] num;
		logic [31:0] wdata;
	} ivs_spr_req_t;

endpackage

// ### sim/ivs_checker.sv
// Port-level checker of the interrupt vector and syndrome block.
// Assumes it is bound to ivs_top and shares its clock and reset.
`timescale 1ns/10ps
module ivs_checker
#(
	parameter logic [15:0] SYN_TYPES = 16'h206E
)
(
	input wire logic clk,
	input wire logic rstn,
	input wire ivs_pkg::ivs_take_t take,
	input wire ivs_pkg::ivs_spr_req_t spr_req,
	input wire logic [31:0] spr_rdata,
	input wire logic spr_rvalid,
	input wire logic spr_miss,
	input wire logic [31:0] vector_addr,
	input wire logic vector_valid,
	input wire ivs_pkg::ivs_int_type_t vector_type,
	input wire logic syndrome_updated
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	wire rec = take.valid && SYN_TYPES[take.int_type];
	chk_take_to_valid: assert property (take.valid |=> vector_valid)
		else $error("vector_valid missing after take");
	chk_valid_has_cause: assert property (vector_valid |-> $past(take.valid))
		else $error("vector_valid without take");
	chk_type_follows: assert property (take.valid |=> vector_type == $past(take.int_type))
		else $error("vector_type wrong");
	chk_addr_aligned: assert property (vector_valid |-> vector_addr[3:0] == 4'h0)
		else $error("vector address low bits not zero");
	chk_addr_holds: assert property (!take.valid |=> $stable(vector_addr))
		else $error("vector address changed without take");
	chk_syn_records: assert property (rec |=> syndrome_updated)
		else $error("recording take did not update syndrome");
	chk_syn_untouched: assert property (!rec |=> !syndrome_updated)
		else $error("syndrome updated by non-recording take");
	chk_read_answer: assert property (spr_rvalid |-> $past(spr_req.rd))
		else $error("read answer without read");
	chk_mapped_no_miss: assert property ((spr_req.wr || spr_req.rd)
		&& spr_req.num >= 10'h100 && spr_req.num <= 10'h111 |=> !spr_miss)
		else $error("miss on mapped register");
	chk_rdata_holds: assert property (!spr_req.rd |=> $stable(spr_rdata))
		else $error("read data changed without read");
	cov_rec_take: cover property (rec ##1 syndrome_updated);
	cov_plain_take: cover property (take.valid && !rec);
	cov_miss: cover property (spr_miss);
endmodule // ivs_checker

// ### sim/ivs_core_model.sv
// Core sequencer model: issues interrupt takes and special-register moves.
// Assumes the bench calls its tasks one at a time.
`timescale 1ns/10ps
module ivs_core_model
(
	input wire logic clk,
	output ivs_pkg::ivs_take_t take,
	output ivs_pkg::ivs_spr_req_t spr_req
);
	initial
	begin
		take = '0;
		spr_req = '0;
	end
	// Released fields carry inverted junk so stale values never look valid.
	task special_purpose_register(input logic w, input logic [9:0] n, input logic [31:0] d);
		@(negedge clk);
		spr_req = {w, !w, n, d};
		@(negedge clk);
		spr_req = {1'b0, 1'b0, ~n, ~d};
	endtask
	task take_it(input logic [3:0] t, input logic [4:0] c);
		@(negedge clk);
		take = {1'b1, t, c};
		@(negedge clk);
		take = {1'b0, ~t, ~c};
	endtask
endmodule // ivs_core_model

// ### sim/ivs_top_tb.sv
// Self-checking bench of the interrupt vector and syndrome block.
// Assumes the package and the core model are compiled first.
`timescale 1ns/10ps
module ivs_top_tb;
	localparam logic [15:0] SYN = 16'h206E;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	ivs_pkg::ivs_take_t take;
	ivs_pkg::ivs_spr_req_t spr_req;
	logic [31:0] spr_rdata, vector_addr, d, exp_pfx, exp_syn;
	logic [31:0] exp_off [16];
	logic spr_rvalid, spr_miss, vector_valid, syndrome_updated;
	ivs_pkg::ivs_int_type_t vector_type;
	logic [3:0] t;
	logic [4:0] c;
	int err_total = 0;
	int tests_run = 0;
	ivs_core_model core (.clk(clk), .take(take), .spr_req(spr_req));
	ivs_top #(.SYN_TYPES(SYN)) dut (.clk(clk), .rstn(rstn), .take(take), .spr_req(spr_req),
		.spr_rdata(spr_rdata), .spr_rvalid(spr_rvalid), .spr_miss(spr_miss),
		.vector_addr(vector_addr), .vector_valid(vector_valid), .vector_type(vector_type),
		.syndrome_updated(syndrome_updated));
	initial
	begin
		forever #5 clk = ~clk;
	end
	function logic [31:0] syn_word(input logic [4:0] k);
		return {k[4], 3'h0, k[3:0], 24'h000000};
	endfunction
	task chk32(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			err_total++;
			$display("MISMATCH %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task chk1(input logic got, input logic exp);
		chk32({31'h00000000, got}, {31'h00000000, exp});
	endtask
	task rd_chk(input logic [9:0] n, input logic [31:0] exp);
		core.special_purpose_register(1'b0, n, 32'h00000000);
		chk1(spr_rvalid, 1'b1);
		chk32(spr_rdata, exp);
	endtask
	task final_report;
		$display("comparisons %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial
	begin
		#50000;
		err_total++;
		final_report();
	end
	initial
	begin
		void'($urandom(32'hC92F));
		repeat (3) @(posedge clk);
		@(negedge clk);
		rstn = 1'b1;
		rd_chk(10'h110, 32'h00000000);
		for (int i = 0; i < 16; i++)
		begin
			d = $urandom;
			core.special_purpose_register(1'b1, 10'h100 + 10'(i), d);
			exp_off[i] = d & 32'h0000FFF0;
		end
		d = $urandom;
		core.special_purpose_register(1'b1, 10'h110, d);
		exp_pfx = d & 32'hFFFF0000;
		core.special_purpose_register(1'b1, 10'h111, 32'hFFFFFFFF);
		exp_syn = 32'h8F000000;
		for (int i = 0; i < 16; i++)
			rd_chk(10'h100 + 10'(i), exp_off[i]);
		rd_chk(10'h110, exp_pfx);
		rd_chk(10'h111, exp_syn);
		rd_chk(10'h112, 32'h00000000);
		core.special_purpose_register(1'b1, 10'h000, 32'h12345678);
		chk1(spr_miss, 1'b1);
		// Every type once with random causes, then each cause bit alone on a program take.
		for (int i = 0; i < 21; i++)
		begin
			t = (i < 16) ? 4'(i) : 4'h6;
			c = (i < 16) ? 5'($urandom) : 5'(1 << (i - 16));
			core.take_it(t, c);
			chk1(vector_valid, 1'b1);
			chk32({28'h0000000, vector_type}, {28'h0000000, t});
			chk32(vector_addr, {exp_pfx[31:16], exp_off[t][15:4], 4'h0});
			chk1(syndrome_updated, SYN[t]);
			if (SYN[t])
				exp_syn = syn_word(c);
			rd_chk(10'h111, exp_syn);
		end
		final_report();
	end
endmodule // ivs_top_tb
bind ivs_top ivs_checker #(.SYN_TYPES(SYN_TYPES)) u_chk (.clk(clk), .rstn(rstn), .take(take),
	.spr_req(spr_req), .spr_rdata(spr_rdata), .spr_rvalid(spr_rvalid), .spr_miss(spr_miss),
	.vector_addr(vector_addr), .vector_valid(vector_valid), .vector_type(vector_type),
	.syndrome_updated(syndrome_updated));
